// >>> rtl/sos_pkg.sv
// Purpose: constants and carrier types for the status output selector
// Assumes: 32-bit Avalon-MM register window, byte addresses, one word per register
// Notes:   all selector registers are 8 bits wide and sit in the low byte
package sos_pkg;

  // register map, byte addresses
  localparam logic [7:0] OUT_SEL_BASE  = 8'h00;
  localparam logic [7:0] IN_SEL_BASE   = 8'h18;
  localparam logic [7:0] OUT_STAT_ADDR = 8'h30;
  localparam logic [7:0] IN_STAT_ADDR  = 8'h34;
  localparam logic [7:0] CODE_ADDR     = 8'h38;
  localparam logic [7:0] SEL_RESET     = 8'h00;
  localparam logic [7:0] OUT_SEL_MAX   = 8'h15;
  localparam logic [7:0] IN_SEL_MAX    = 8'h17;

  // output selector codes
  localparam logic [4:0] SEL_NONE     = 5'h00;
  localparam logic [4:0] SEL_RUN      = 5'h01;
  localparam logic [4:0] SEL_FREQ_OK  = 5'h02;
  localparam logic [4:0] SEL_ZERO_CMD = 5'h03;
  localparam logic [4:0] SEL_TORQUE   = 5'h04;
  localparam logic [4:0] SEL_BLOCK    = 5'h05;
  localparam logic [4:0] SEL_UNDERV   = 5'h06;
  localparam logic [4:0] SEL_EXT_MODE = 5'h07;
  localparam logic [4:0] SEL_FAULT    = 5'h08;
  localparam logic [4:0] SEL_DESIRED  = 5'h09;
  localparam logic [4:0] SEL_CNT_TERM = 5'h0A;
  localparam logic [4:0] SEL_CNT_PRE  = 5'h0B;
  localparam logic [4:0] SEL_OV_STALL = 5'h0C;
  localparam logic [4:0] SEL_OC_STALL = 5'h0D;
  localparam logic [4:0] SEL_HOT      = 5'h0E;
  localparam logic [4:0] SEL_DC_OVER  = 5'h0F;
  localparam logic [4:0] SEL_LOOP     = 5'h10;
  localparam logic [4:0] SEL_FWD      = 5'h11;
  localparam logic [4:0] SEL_REV      = 5'h12;
  localparam logic [4:0] SEL_ZERO_OUT = 5'h13;
  localparam logic [4:0] SEL_COMM     = 5'h14;
  localparam logic [4:0] SEL_BRAKE    = 5'h15;

  // input selector codes
  localparam logic [7:0] IN_STEP_BIT0 = 8'h01;
  localparam logic [7:0] IN_STEP_BIT1 = 8'h02;

  // drive fault sources
  typedef struct packed {
    logic overcurrent;
    logic overvoltage;
    logic overheat;
    logic overload;
    logic ext_fault;
    logic ground_fault;
  } sos_faults_s;

  // communication class warnings
  typedef struct packed {
    logic feedback_err;
    logic comm_err;
    logic overload_warn;
    logic save_warn;
  } sos_warn_s;

  // status conditions from the drive control logic
  typedef struct packed {
    logic        ready;
    logic        run_cmd;
    logic        stop_cmd;
    logic        freq_attained;
    logic        cmd_below_min;
    logic        over_torque;
    logic        output_blocked;
    logic        undervoltage;
    logic        ext_cmd_source;
    sos_faults_s faults;
    logic        desired_attained;
    logic        count_terminal;
    logic        count_prelim;
    logic        ov_stall;
    logic        oc_stall;
    logic        heatsink_warn;
    logic        dcbus_over;
    logic        process_loop_control;
    logic        forward_dir;
    logic        reverse_dir;
    logic        freq_delivered;
    sos_warn_s   warnings;
    logic        freq_ge_upper;
    logic        freq_le_lower;
  } sos_status_s;

  // brake sequencing
  typedef enum logic [1:0] {
    BRAKE_IDLE,
    BRAKE_HELD,
    BRAKE_STOPPING
  } sos_brake_e;

endpackage

// >>> rtl/sos_status_output_selector.sv
// Purpose: routes drive status conditions to six extension output terminals and
//          decodes six extension input terminals, all set by selector registers
// Assumes: status and terminal inputs are synchronous to clk_i
// Notes:   register access is Avalon-MM with one wait state per transfer
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
module sos_status_output_selector
#(
  parameter int N_OUT = 6,
  parameter int N_IN  = 6
)
(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               reset_n_i,
  // avalon-mm slave
  input  wire logic [7:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  input  wire logic [3:0]         avs_byteenable_i,
  output logic      [31:0]        avs_readdata_o,
  output logic                    avs_waitrequest_o,
  // drive status conditions
  input  wire sos_pkg::sos_status_s status_i,
  // extension terminals
  input  wire logic [N_IN-1:0]    ext_input_i,
  output logic      [N_OUT-1:0]   ext_output_o,
  // multi-step speed code to the frequency selector
  output logic      [3:0]         step_code_o
);

  localparam int N_SEL = N_OUT + N_IN;

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0]           sel_reg [N_SEL];
  logic                 wait_reg;
  logic [31:0]          rdata_reg;
  logic [N_OUT-1:0]     ext_out_reg;
  logic [N_OUT-1:0]     ext_out_next;
  logic [3:0]           code_reg;
  logic [3:0]           code_next;
  logic [31:0]          cond;
  logic                 brake_on;
  logic                 acc_req;
  logic                 acc_go;
  logic [5:0]           word_idx;
  sos_pkg::sos_brake_e  brake_reg;
  sos_pkg::sos_brake_e  brake_next;

  //////////////////////////////////////////////////////////////////////////////
  // bus handshake

  // a request is seen with waitrequest high, answered one cycle later
  assign acc_req  = avs_read_i | avs_write_i;
  assign acc_go   = acc_req & ~wait_reg;
  assign word_idx = avs_address_i[7:2];

  // waitrequest drops for exactly one cycle per request
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      wait_reg <= 1'b1;
    else if (acc_req && wait_reg)
      wait_reg <= 1'b0;
    else
      wait_reg <= 1'b1;
  end

  // read data is captured while waitrequest is still high
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_reg <= 32'h0000_0000;
    else if (avs_read_i && wait_reg)
    begin
      rdata_reg <= 32'h0000_0000;
      if (word_idx < 6'(N_SEL))
        rdata_reg[7:0] <= sel_reg[word_idx[3:0]];
      else if (avs_address_i[7:2] == sos_pkg::OUT_STAT_ADDR[7:2])
        rdata_reg[N_OUT-1:0] <= ext_out_reg;
      else if (avs_address_i[7:2] == sos_pkg::IN_STAT_ADDR[7:2])
        rdata_reg[N_IN-1:0] <= ext_input_i;
      else if (avs_address_i[7:2] == sos_pkg::CODE_ADDR[7:2])
        rdata_reg[3:0] <= code_reg;
    end
  end

  assign avs_readdata_o    = rdata_reg;
  assign avs_waitrequest_o = wait_reg;

  //////////////////////////////////////////////////////////////////////////////
  // selector registers

  // out-of-range values are refused and the old setting kept
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < N_SEL; i++)
        sel_reg[i] <= sos_pkg::SEL_RESET;
    end
    else if (acc_go && avs_write_i && avs_byteenable_i[0] && word_idx < 6'(N_SEL))
    begin
      if (word_idx < 6'(N_OUT))
      begin
        if (avs_writedata_i[7:0] <= sos_pkg::OUT_SEL_MAX)
          sel_reg[word_idx[3:0]] <= avs_writedata_i[7:0];
      end
      else if (avs_writedata_i[7:0] <= sos_pkg::IN_SEL_MAX)
        sel_reg[word_idx[3:0]] <= avs_writedata_i[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // brake control sequence

  // held from the upper threshold until a stop has brought frequency low
  always_comb
  begin
    brake_next = brake_reg;
    unique case (brake_reg)
      sos_pkg::BRAKE_IDLE:
        if (status_i.freq_ge_upper)
          brake_next = sos_pkg::BRAKE_HELD;
      sos_pkg::BRAKE_HELD:
        if (status_i.stop_cmd && status_i.freq_le_lower)
          brake_next = sos_pkg::BRAKE_IDLE;
        else if (status_i.stop_cmd)
          brake_next = sos_pkg::BRAKE_STOPPING;
      sos_pkg::BRAKE_STOPPING:
        if (status_i.freq_le_lower)
          brake_next = sos_pkg::BRAKE_IDLE;
        else if (status_i.run_cmd && !status_i.stop_cmd)
          brake_next = sos_pkg::BRAKE_HELD;
    endcase
  end

  // brake state register
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      brake_reg <= sos_pkg::BRAKE_IDLE;
    else
      brake_reg <= brake_next;
  end

  assign brake_on = (brake_reg != sos_pkg::BRAKE_IDLE);

  //////////////////////////////////////////////////////////////////////////////
  // condition vector indexed by selector value

  always_comb
  begin
    cond                         = 32'h0000_0000;
    cond[sos_pkg::SEL_NONE]      = 1'b0;
    cond[sos_pkg::SEL_RUN]       = status_i.ready | status_i.run_cmd;
    cond[sos_pkg::SEL_FREQ_OK]   = status_i.freq_attained;
    cond[sos_pkg::SEL_ZERO_CMD]  = status_i.cmd_below_min;
    cond[sos_pkg::SEL_TORQUE]    = status_i.over_torque;
    cond[sos_pkg::SEL_BLOCK]     = status_i.output_blocked;
    cond[sos_pkg::SEL_UNDERV]    = status_i.undervoltage;
    cond[sos_pkg::SEL_EXT_MODE]  = status_i.ext_cmd_source;
    cond[sos_pkg::SEL_FAULT]     = |status_i.faults;
    cond[sos_pkg::SEL_DESIRED]   = status_i.desired_attained;
    cond[sos_pkg::SEL_CNT_TERM]  = status_i.count_terminal;
    cond[sos_pkg::SEL_CNT_PRE]   = status_i.count_prelim;
    cond[sos_pkg::SEL_OV_STALL]  = status_i.ov_stall;
    cond[sos_pkg::SEL_OC_STALL]  = status_i.oc_stall;
    cond[sos_pkg::SEL_HOT]       = status_i.heatsink_warn;
    cond[sos_pkg::SEL_DC_OVER]   = status_i.dcbus_over;
    cond[sos_pkg::SEL_LOOP]      = status_i.process_loop_control;
    cond[sos_pkg::SEL_FWD]       = status_i.forward_dir;
    cond[sos_pkg::SEL_REV]       = status_i.reverse_dir;
    cond[sos_pkg::SEL_ZERO_OUT]  = ~status_i.freq_delivered;
    cond[sos_pkg::SEL_COMM]      = |status_i.warnings;
    cond[sos_pkg::SEL_BRAKE]     = brake_on;
  end

  //////////////////////////////////////////////////////////////////////////////
  // terminal routing

  // each output picks its condition; selector 0 picks the constant low bit
  always_comb
  begin
    for (int i = 0; i < N_OUT; i++)
      ext_out_next[i] = cond[sel_reg[i][4:0]];
  end

  // multi-step code bits from inputs programmed 1 and 2; others have no effect
  always_comb
  begin
    code_next = 4'h0;
    for (int i = 0; i < N_IN; i++)
    begin
      if (sel_reg[N_OUT + i] == sos_pkg::IN_STEP_BIT0 && ext_input_i[i])
        code_next[0] = 1'b1;
      if (sel_reg[N_OUT + i] == sos_pkg::IN_STEP_BIT1 && ext_input_i[i])
        code_next[1] = 1'b1;
    end
  end

  // terminal outputs come from flops
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ext_out_reg <= '0;
    else
      ext_out_reg <= ext_out_next;
  end

  // speed code register
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      code_reg <= 4'h0;
    else
      code_reg <= code_next;
  end

  assign ext_output_o = ext_out_reg;
  assign step_code_o  = code_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (!reset_n_i);

  // write of any output selector value to terminal 0, legal or not
  sequence s_out0_write;
    acc_go && avs_write_i && avs_byteenable_i[0] && word_idx == 6'h00;
  endsequence

  // stop seen while held, then frequency low while stopping
  sequence s_brake_release;
    brake_reg == sos_pkg::BRAKE_HELD && status_i.stop_cmd
      ##1 brake_reg == sos_pkg::BRAKE_STOPPING && status_i.freq_le_lower;
  endsequence

  a_sel_range_kept: assert property (
    (s_out0_write and avs_writedata_i[7:0] > sos_pkg::OUT_SEL_MAX) |=> $stable(sel_reg[0]))
    else $error("out of range selector value was stored");

  a_sel_legal_store: assert property (
    (s_out0_write and avs_writedata_i[7:0] <= sos_pkg::OUT_SEL_MAX)
      |=> sel_reg[0] == $past(avs_writedata_i[7:0]))
    else $error("legal selector value not stored");

  a_sel_readback: assert property (
    avs_read_i && wait_reg && word_idx == 6'h00 |=> avs_readdata_o[7:0] == $past(sel_reg[0]))
    else $error("selector read back mismatch");

  a_in_sel_range: assert property (
    acc_go && avs_write_i && avs_byteenable_i[0] && word_idx == 6'h06
      && avs_writedata_i[7:0] > sos_pkg::IN_SEL_MAX |=> $stable(sel_reg[N_OUT]))
    else $error("out of range input selector value was stored");

  a_zero_sel_idle: assert property (
    (sel_reg[0] == 8'h00) [*2] |-> !ext_out_reg[0])
    else $error("terminal active with selector zero");

  a_run_follows: assert property (
    sel_reg[0] == 8'h01 |=> ext_out_reg[0] == $past(status_i.ready | status_i.run_cmd))
    else $error("run indication does not follow status");

  a_torque_exact: assert property (
    sel_reg[0] == 8'h04 ##1 sel_reg[0] == 8'h04
      |-> ext_out_reg[0] == $past(status_i.over_torque))
    else $error("over-torque output mismatch");

  a_fault_any: assert property (
    sel_reg[0] == 8'h08 && (|status_i.faults) |=> ext_out_reg[0])
    else $error("fault not shown");

  a_zero_out_sig: assert property (
    sel_reg[0] == 8'h13 && status_i.freq_delivered |=> !ext_out_reg[0])
    else $error("zero speed active while frequency delivered");

  a_comm_warn: assert property (
    sel_reg[0] == 8'h14 |=> ext_out_reg[0] == $past(|status_i.warnings))
    else $error("communication warning output mismatch");

  a_brake_set: assert property (
    brake_reg == sos_pkg::BRAKE_IDLE && status_i.freq_ge_upper |=> brake_on)
    else $error("brake not engaged at upper threshold");

  a_brake_held: assert property (
    brake_on && !status_i.stop_cmd && brake_reg == sos_pkg::BRAKE_HELD |=> brake_on)
    else $error("brake released without stop");

  a_brake_free: assert property (
    s_brake_release |=> !brake_on)
    else $error("brake not released after stop at low frequency");

  a_step_code: assert property (
    sel_reg[N_OUT] == sos_pkg::IN_STEP_BIT1 && ext_input_i[0] |=> step_code_o[1])
    else $error("step code bit one missing");

  a_in_none_quiet: assert property (
    sel_reg[N_OUT] == 8'h00 && sel_reg[N_OUT+1] == 8'h00 && sel_reg[N_OUT+2] == 8'h00
      && sel_reg[N_OUT+3] == 8'h00 && sel_reg[N_OUT+4] == 8'h00
      && sel_reg[N_OUT+5] == 8'h00 |=> step_code_o == 4'h0)
    else $error("unused input terminals affected the step code");

  a_step_bit0: assert property (
    sel_reg[N_OUT+1] == sos_pkg::IN_STEP_BIT0 && ext_input_i[1] |=> step_code_o[0])
    else $error("step code bit zero missing");

  a_freq_ok_out: assert property (
    sel_reg[1] == 8'h02 |=> ext_out_reg[1] == $past(status_i.freq_attained))
    else $error("frequency attained output mismatch");

  a_below_min_out: assert property (
    sel_reg[2] == 8'h03 |=> ext_out_reg[2] == $past(status_i.cmd_below_min))
    else $error("below minimum output mismatch");

  a_block_out: assert property (
    sel_reg[3] == 8'h05 |=> ext_out_reg[3] == $past(status_i.output_blocked))
    else $error("output blocking indication mismatch");

  a_underv_out: assert property (
    sel_reg[4] == 8'h06 |=> ext_out_reg[4] == $past(status_i.undervoltage))
    else $error("undervoltage output mismatch");

  a_ext_mode_out: assert property (
    sel_reg[5] == 8'h07 |=> ext_out_reg[5] == $past(status_i.ext_cmd_source))
    else $error("command source output mismatch");

  a_desired_out: assert property (
    sel_reg[1] == 8'h09 |=> ext_out_reg[1] == $past(status_i.desired_attained))
    else $error("desired frequency output mismatch");

  a_cnt_term_out: assert property (
    sel_reg[2] == 8'h0A |=> ext_out_reg[2] == $past(status_i.count_terminal))
    else $error("terminal count output mismatch");

  a_cnt_pre_out: assert property (
    sel_reg[3] == 8'h0B |=> ext_out_reg[3] == $past(status_i.count_prelim))
    else $error("preliminary count output mismatch");

  a_ov_stall_out: assert property (
    sel_reg[4] == 8'h0C |=> ext_out_reg[4] == $past(status_i.ov_stall))
    else $error("voltage stall output mismatch");

  a_oc_stall_out: assert property (
    sel_reg[5] == 8'h0D |=> ext_out_reg[5] == $past(status_i.oc_stall))
    else $error("current stall output mismatch");

  a_hot_warn_out: assert property (
    sel_reg[1] == 8'h0E |=> ext_out_reg[1] == $past(status_i.heatsink_warn))
    else $error("heatsink warning output mismatch");

  a_dc_over_out: assert property (
    sel_reg[2] == 8'h0F |=> ext_out_reg[2] == $past(status_i.dcbus_over))
    else $error("bus voltage output mismatch");

  a_loop_run_out: assert property (
    sel_reg[3] == 8'h10 |=> ext_out_reg[3] == $past(status_i.process_loop_control))
    else $error("process loop output mismatch");

  a_fwd_dir_out: assert property (
    sel_reg[4] == 8'h11 |=> ext_out_reg[4] == $past(status_i.forward_dir))
    else $error("forward direction output mismatch");

  a_rev_dir_out: assert property (
    sel_reg[5] == 8'h12 |=> ext_out_reg[5] == $past(status_i.reverse_dir))
    else $error("reverse direction output mismatch");

  a_bus_answer: assert property (
    acc_req && wait_reg |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one cycle after request");

endmodule

// >>> sim/sos_terminal_model.sv
// Purpose: external contacts and relays wired to the extension terminals
// Assumes: contacts change just after a rising clock edge
// Notes:   relay coils loop back onto the contacts, so outputs disturb inputs
`timescale 1ns/1ns
module sos_terminal_model
(
  // clock
  input  wire logic       clk_i,
  // relay coils driven by the output terminals
  input  wire logic [5:0] ext_output_i,
  // contacts seen by the input terminals
  output logic      [5:0] ext_input_o
);
  logic [7:0] tick_reg  = 8'h00;
  logic [5:0] relay_reg = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // contacts bounce on a free pattern mixed with relay feedback
  always @(posedge clk_i)
  begin
    tick_reg  <= tick_reg + 8'h1D;
    relay_reg <= ext_output_i;
  end

  // contact levels, stable between rising edges
  assign ext_input_o = tick_reg[7:2] ^ {tick_reg[1:0], relay_reg[5:2]};
endmodule

// >>> sim/test_status_output_selector.sv
// Purpose: self-checking bench for the status output selector
// Assumes: one wait state register bus, outputs registered one cycle late
// Notes:   a cycle model predicts the terminals and is compared every cycle
`timescale 1ns/1ns
`define CHECK(g, e) chk(32'(g), 32'(e))
module test_status_output_selector;
  logic                 clk_i            = 1'b0;
  logic                 reset_n_i        = 1'b0;
  logic [7:0]           avs_address_i    = 8'h00;
  logic                 avs_read_i       = 1'b0;
  logic                 avs_write_i      = 1'b0;
  logic [31:0]          avs_writedata_i  = 32'h0;
  logic [3:0]           avs_byteenable_i = 4'hF;
  logic [31:0]          avs_readdata_o;
  logic                 avs_waitrequest_o;
  sos_pkg::sos_status_s status_i         = '0;
  logic [5:0]           ext_input_i;
  logic [5:0]           ext_output_o;
  logic [3:0]           step_code_o;
  logic [31:0]          seed             = 32'hB78821B5;
  logic [63:0]          rnd;
  logic [7:0]           osel[6]          = '{default: 8'h00};
  logic [7:0]           isel[6]          = '{default: 8'h00};
  logic [5:0]           exp_out;
  logic [3:0]           exp_code;
  logic [31:0]          q;
  int                   bst, error_cnt, checked, cyc;
  bit                   armed;

  always #4 clk_i = ~clk_i;

  sos_status_output_selector i_sos_status_output_selector (.*);
  sos_terminal_model i_sos_terminal_model
  (
    .clk_i        (clk_i),
    .ext_output_i (ext_output_o),
    .ext_input_o  (ext_input_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // condition routed by an output selector value
  function automatic logic cond(input logic [7:0] v, input sos_pkg::sos_status_s s);
    case (v)
      1: return s.ready | s.run_cmd;
      2: return s.freq_attained;
      3: return s.cmd_below_min;
      4: return s.over_torque;
      5: return s.output_blocked;
      6: return s.undervoltage;
      7: return s.ext_cmd_source;
      8: return |s.faults;
      9: return s.desired_attained;
      10: return s.count_terminal;
      11: return s.count_prelim;
      12: return s.ov_stall;
      13: return s.oc_stall;
      14: return s.heatsink_warn;
      15: return s.dcbus_over;
      16: return s.process_loop_control;
      17: return s.forward_dir;
      18: return s.reverse_dir;
      19: return !s.freq_delivered;
      20: return |s.warnings;
      21: return bst != 0;
      default: return 1'b0;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one register transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    avs_address_i    <= a;
    avs_write_i      <= wr;
    avs_read_i       <= !wr;
    avs_writedata_i  <= {xs()} & 32'hFFFF_FF00 | {24'h0, d};
    avs_byteenable_i <= be;
    do
    begin
      @(posedge clk_i);
    end
    while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    if (wr && be[0] && a < sos_pkg::IN_SEL_BASE && d <= sos_pkg::OUT_SEL_MAX)
      osel[a[7:2]] = d;
    else if (wr && be[0] && a >= sos_pkg::IN_SEL_BASE && a < sos_pkg::OUT_STAT_ADDR
             && d <= sos_pkg::IN_SEL_MAX)
      isel[a[7:2] - 6] = d;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // random drive conditions and hang guard
  always @(posedge clk_i)
  begin
    rnd = {xs(), xs()};
    status_i <= rnd[$bits(sos_pkg::sos_status_s)-1:0];
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  // cycle model: predict the next edge from what is stable now
  always @(negedge clk_i)
  begin
    if (!reset_n_i)
    begin
      bst   = 0;
      armed = 0;
      osel  = '{default: 8'h00};
      isel  = '{default: 8'h00};
    end
    else
    begin
      if (armed)
      begin
        `CHECK(ext_output_o, exp_out);
        `CHECK(ext_output_o, exp_out);
        `CHECK(step_code_o, exp_code);
      end
      // outputs see the brake state held now, before it steps
      exp_code = 4'h0;
      for (int t = 0; t < 6; t++)
      begin
        exp_out[t] = cond(osel[t], status_i);
        exp_code[0] |= (isel[t] == 8'h01) & ext_input_i[t];
        exp_code[1] |= (isel[t] == 8'h02) & ext_input_i[t];
      end
      case (bst)
        0: bst = status_i.freq_ge_upper ? 1 : 0;
        1: bst = (status_i.stop_cmd && status_i.freq_le_lower) ? 0 : (status_i.stop_cmd ? 2 : 1);
        default: bst = status_i.freq_le_lower ? 0
                     : ((status_i.run_cmd && !status_i.stop_cmd) ? 1 : 2);
      endcase
      armed = 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    // every selector starts at zero, an unmapped word reads zero
    for (int i = 0; i < 12; i++)
    begin
      bus(1'b0, 8'(4 * i), 8'h00, 4'hF);
      `CHECK(q, 32'h0);
    end
    bus(1'b0, 8'h3C, 8'h00, 4'hF);
    `CHECK(q, 32'h0);
    $display("test reset_values done");
    // input terminals on codes 0 to 3, then range limit
    for (int k = 0; k < 4; k++)
    begin
      for (int t = 0; t < 6; t++)
        bus(1'b1, sos_pkg::IN_SEL_BASE + 8'(4 * t), 8'((t + k) % 4), 4'hF);
      repeat (30) @(posedge clk_i);
    end
    bus(1'b1, sos_pkg::IN_SEL_BASE, 8'h17, 4'hF);
    bus(1'b1, sos_pkg::IN_SEL_BASE, 8'h18, 4'hF);
    for (int t = 0; t < 6; t++)
    begin
      bus(1'b0, sos_pkg::IN_SEL_BASE + 8'(4 * t), 8'h00, 4'hF);
      `CHECK(q, osel[0] & 8'h00 | isel[t]);
    end
    $display("test input_decode done");
    // every output code on every terminal, back to back writes
    for (int b = 0; b < 22; b++)
    begin
      for (int t = 0; t < 6; t++)
        bus(1'b1, sos_pkg::OUT_SEL_BASE + 8'(4 * t), 8'((b + t) % 22), 4'hF);
      repeat (20) @(posedge clk_i);
    end
    bus(1'b1, sos_pkg::OUT_SEL_BASE, 8'h16, 4'hF);
    bus(1'b1, sos_pkg::OUT_SEL_BASE + 8'h04, 8'h05, 4'h0);
    for (int t = 0; t < 6; t++)
    begin
      bus(1'b0, sos_pkg::OUT_SEL_BASE + 8'(4 * t), 8'h00, 4'hF);
      `CHECK(q, osel[t]);
    end
    $display("test output_routing done");
    // mid-run reset returns every selector to zero
    reset_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 12; i++)
    begin
      bus(1'b0, 8'(4 * i), 8'h00, 4'hF);
      `CHECK(q, 32'h0);
    end
    $display("test mid_run_reset done");
    print_verdict();
  end
endmodule
